// ===== common/ssq_pkg.sv
// Shared constants of the stop and link fault sequencer
package ssq_pkg;
    // Register byte offsets
    localparam logic [7:0] SSQ_CTRL_OFS = 8'h00;
    localparam logic [7:0] SSQ_WAIT_OFS = 8'h04;
    localparam logic [7:0] SSQ_COUNT_OFS = 8'h08;
    localparam logic [7:0] SSQ_STATUS_OFS = 8'h0C;
    localparam logic [7:0] SSQ_HIST_OFS = 8'h10;
    // Control, wait and count register fields
    localparam int SSQ_STOP_LSB = 0;
    localparam int SSQ_STOP_W = 14;
    localparam int SSQ_MODE_LSB = 16;
    localparam int SSQ_MODE_W = 2;
    localparam int SSQ_WAIT_W = 14;
    localparam int SSQ_CNT_W = 16;
    // Stop method encodings and ranges, wait time maximum
    localparam logic [13:0] SSQ_STOP_DECEL = 14'h270F;
    localparam logic [13:0] SSQ_STOP_TWO_WIRE = 14'h22B8;
    localparam logic [13:0] SSQ_STOP_SHORT_MAX = 14'h0064;
    localparam logic [13:0] SSQ_STOP_LONG_MIN = 14'h03E8;
    localparam logic [13:0] SSQ_STOP_LONG_MAX = 14'h044C;
    localparam logic [13:0] SSQ_WAIT_MAX = 14'h270E;
    // Fault stop modes
    localparam logic [1:0] SSQ_MODE_COAST = 2'h0;
    localparam logic [1:0] SSQ_MODE_DECEL_ALARM = 2'h1;
    localparam logic [1:0] SSQ_MODE_DECEL_RESTART = 2'h2;
    // Fault data codes
    localparam logic [7:0] SSQ_LINE_CODE = 8'hA0;
    localparam logic [7:0] SSQ_MCU_CODE = 8'hF3;
    // Reset values
    localparam logic [13:0] SSQ_STOP_RESET = SSQ_STOP_DECEL;
    localparam logic [1:0] SSQ_MODE_RESET = SSQ_MODE_COAST;
    localparam logic [13:0] SSQ_WAIT_RESET = 14'h0000;
    // Timing
    localparam longint SSQ_CLK_PERIOD_NS = 50;
    localparam longint SSQ_TENTH_NS = 100000000;
    localparam int SSQ_TENTH_CYCLES = int'((SSQ_TENTH_NS + SSQ_CLK_PERIOD_NS - 1)
                                           / SSQ_CLK_PERIOD_NS);
    localparam int SSQ_TENTHS_PER_SEC = 10;
    localparam int SSQ_SAVE_TENTHS = 36000;
    // Sequencer states, one-hot
    typedef enum logic [6:0] {
        SSQ_IDLE = 7'h01,
        SSQ_RUN = 7'h02,
        SSQ_DECEL = 7'h04,
        SSQ_DELAY = 7'h08,
        SSQ_COAST = 7'h10,
        SSQ_FDECEL = 7'h20,
        SSQ_FHOLD = 7'h40
    } ssq_state_e;
endpackage : ssq_pkg

// ===== design/ssq_sequencer.sv
// Stop method and link fault sequencer with APB registers
`timescale 1ns/1ps
// Overview of operation
// (R1) 9999: decelerate to stop on run removal
// (R2) 0-100 s: coast after delay elapses
// (R3) 8888: forward runs, reverse selects direction
// (R4) 1000-1100: two-wire inputs, coast after delay
// (R5) Running indicator drops when output stops
// (R6) Restart while coasting begins at zero
// (R7) Zero delay cuts output at once
// (R8) Line fault recognised after full wait
// (R9) Early line recovery raises no fault
// (R10) Count every line fault onset except one in the restore cycle after reset
// (R11) Software clears counter by writing zero
// (R12) Counter saved hourly, restored after reset
// (R13) Recognised fault reaction per stop mode
// (R14) After clearing: hold in 0/1, restart 2
// (R15) Internal fault acts at once, holds
// (R16) Codes A0 line, F3 internal
// (R17) Alarm on relay and status bit
// (R18) Fault ramps use normal ramp times
// (R19) Mode 2 restart resumes prior command
// (R20) Mode 2 reaccelerates if cleared decelerating
// (R21) History written only when alarm asserted
// (R22) Wait timer restarts at onset, clears
module ssq_sequencer
    import ssq_pkg::*;
#(
    parameter int TENTH_CYCLES = SSQ_TENTH_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Run inputs and fault sources
    input wire logic forward_run_input_in,
    input wire logic reverse_run_input_in,
    input wire logic line_fault_in,
    input wire logic mcu_fault_in,
    input wire logic motor_stopped_in,
    // Non-volatile counter store
    input wire logic [15:0] nv_count_in,
    output logic [15:0] nv_count_out,
    output logic nv_save_out,
    // Drive control
    output logic drive_enable_out,
    output logic decel_out,
    output logic start_from_zero_out,
    output logic reverse_out,
    output logic running_out,
    // Fault reporting
    output logic fault_relay_output_out,
    output logic alarm_bit_out,
    output logic [7:0] line_fault_code_out,
    output logic [7:0] display_code_out
);
    ssq_state_e state_reg, state_next;
    logic [13:0] stop_method_setting_reg;
    logic [1:0] fault_stop_mode_reg;
    logic [13:0] line_fault_wait_time_reg;
    logic [15:0] line_fault_counter_reg;
    logic [7:0] history_reg;
    logic restore_reg;
    logic [31:0] tenth_cnt_reg;
    logic [3:0] sec_cnt_reg;
    logic [31:0] wait_pre_reg;
    logic [13:0] wait_cnt_reg;
    logic [15:0] save_cnt_reg;
    logic [6:0] delay_cnt_reg;
    logic line_prev_reg, line_recog_reg, mcu_seen_reg;
    logic saved_rev_reg;
    logic alarm_reg, pending_alarm_reg;
    logic [7:0] code_reg, pending_code_reg;
    logic tenth_tick, sec_tick, two_wire, run_cmd, rev_cmd, delay_done, line_onset;
    logic wr_en, rd_setup, addr_ok, clear_write;
    logic [31:0] rd_data;
    logic [6:0] delay_secs;

    function automatic logic is_long(input logic [13:0] s);
        is_long = (s >= SSQ_STOP_LONG_MIN) && (s <= SSQ_STOP_LONG_MAX);
    endfunction : is_long

    // APB decode
    assign rd_setup = psel_in && !penable_in;
    assign wr_en = psel_in && penable_in && pready_out && pwrite_in && addr_ok;
    assign clear_write = wr_en && (paddr_in == SSQ_COUNT_OFS) && (pwdata_in == 32'h0);
    assign line_onset = line_fault_in && !line_prev_reg;

    always_comb begin
        addr_ok = 1'b1;
        rd_data = 32'h0;
        case (paddr_in)
            SSQ_CTRL_OFS: begin
                rd_data[SSQ_STOP_LSB +: SSQ_STOP_W] = stop_method_setting_reg;
                rd_data[SSQ_MODE_LSB +: SSQ_MODE_W] = fault_stop_mode_reg;
            end
            SSQ_WAIT_OFS: rd_data[SSQ_WAIT_W-1:0] = line_fault_wait_time_reg;
            SSQ_COUNT_OFS: rd_data[SSQ_CNT_W-1:0] = line_fault_counter_reg;
            SSQ_STATUS_OFS: rd_data = {8'h00, code_reg, 9'h000, state_reg};
            SSQ_HIST_OFS: rd_data = {24'h000000, history_reg};
            default: addr_ok = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
        end else begin
            pready_out <= rd_setup;
            pslverr_out <= rd_setup && !addr_ok;
            if (rd_setup) begin
                prdata_out <= pwrite_in ? 32'h0 : rd_data;
            end
        end
    end

    // Settings registers
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stop_method_setting_reg <= SSQ_STOP_RESET;
            fault_stop_mode_reg <= SSQ_MODE_RESET;
            line_fault_wait_time_reg <= SSQ_WAIT_RESET;
        end else if (wr_en) begin
            if (paddr_in == SSQ_CTRL_OFS) begin
                stop_method_setting_reg <= pwdata_in[SSQ_STOP_LSB +: SSQ_STOP_W];
                if (pwdata_in[SSQ_MODE_LSB +: SSQ_MODE_W] <= SSQ_MODE_DECEL_RESTART) begin
                    fault_stop_mode_reg <= pwdata_in[SSQ_MODE_LSB +: SSQ_MODE_W];
                end
            end
            if (paddr_in == SSQ_WAIT_OFS && pwdata_in[SSQ_WAIT_W-1:0] <= SSQ_WAIT_MAX) begin
                line_fault_wait_time_reg <= pwdata_in[SSQ_WAIT_W-1:0];
            end
        end
    end

    // Tenth-second and second timebase
    assign tenth_tick = (tenth_cnt_reg == 32'(TENTH_CYCLES - 1));
    assign sec_tick = tenth_tick && (sec_cnt_reg == 4'(SSQ_TENTHS_PER_SEC - 1));
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tenth_cnt_reg <= 32'h0;
            sec_cnt_reg <= 4'h0;
        end else begin
            tenth_cnt_reg <= tenth_tick ? 32'h0 : tenth_cnt_reg + 32'h1;
            if (tenth_tick) begin
                sec_cnt_reg <= sec_tick ? 4'h0 : sec_cnt_reg + 4'h1;
            end
        end
    end

    // Counter, hourly save and restore
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            line_fault_counter_reg <= 16'h0;
            restore_reg <= 1'b1;
            save_cnt_reg <= 16'h0;
            nv_save_out <= 1'b0;
            nv_count_out <= 16'h0;
            line_prev_reg <= 1'b0;
        end else begin
            restore_reg <= 1'b0;
            line_prev_reg <= line_fault_in;
            nv_save_out <= 1'b0;
            if (restore_reg) begin
                line_fault_counter_reg <= nv_count_in; // R12
            end else if (line_onset) begin
                line_fault_counter_reg <= clear_write ? 16'h1 : line_fault_counter_reg + 16'h1; // R10
            end else if (clear_write) begin
                line_fault_counter_reg <= 16'h0; // R11
            end
            if (tenth_tick) begin
                save_cnt_reg <= (save_cnt_reg == 16'(SSQ_SAVE_TENTHS - 1)) ? 16'h0
                              : save_cnt_reg + 16'h1;
                if (save_cnt_reg == 16'(SSQ_SAVE_TENTHS - 1)) begin
                    nv_save_out <= 1'b1; // R12
                    nv_count_out <= line_fault_counter_reg;
                end
            end
        end
    end

    // Line fault recognition timer
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_pre_reg <= 32'h0;
            wait_cnt_reg <= 14'h0;
            line_recog_reg <= 1'b0;
        end else if (!line_fault_in || line_onset) begin
            wait_pre_reg <= 32'h0; // R22
            wait_cnt_reg <= 14'h0;
            line_recog_reg <= 1'b0; // R9
        end else begin
            if (wait_cnt_reg >= line_fault_wait_time_reg) begin
                line_recog_reg <= 1'b1; // R8
            end else if (wait_pre_reg == 32'(TENTH_CYCLES - 1)) begin
                wait_pre_reg <= 32'h0;
                wait_cnt_reg <= wait_cnt_reg + 14'h1;
            end else begin
                wait_pre_reg <= wait_pre_reg + 32'h1;
            end
        end
    end

    // Run command decode
    assign two_wire = (stop_method_setting_reg == SSQ_STOP_TWO_WIRE)
                   || is_long(stop_method_setting_reg);
    always_comb begin
        if (two_wire) begin
            run_cmd = forward_run_input_in; // R3 R4
            rev_cmd = reverse_run_input_in;
        end else begin
            run_cmd = forward_run_input_in ^ reverse_run_input_in;
            rev_cmd = reverse_run_input_in;
        end
    end
    assign delay_secs = is_long(stop_method_setting_reg)
        ? 7'(stop_method_setting_reg - SSQ_STOP_LONG_MIN)
        : 7'(stop_method_setting_reg);
    assign delay_done = (delay_cnt_reg >= delay_secs);

    // Stop delay counter
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            delay_cnt_reg <= 7'h0;
        end else if (state_reg != SSQ_DELAY) begin
            delay_cnt_reg <= 7'h0;
        end else if (sec_tick && !delay_done) begin
            delay_cnt_reg <= delay_cnt_reg + 7'h1; // R2 R4
        end
    end

    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SSQ_IDLE, SSQ_COAST: begin
                if (run_cmd) begin
                    state_next = SSQ_RUN; // R6
                end
            end
            SSQ_RUN, SSQ_DELAY: begin
                if (!run_cmd) begin
                    if (stop_method_setting_reg == SSQ_STOP_DECEL
                        || stop_method_setting_reg == SSQ_STOP_TWO_WIRE) begin
                        state_next = SSQ_DECEL; // R1 R3
                    end else if (state_reg == SSQ_RUN && delay_secs != 7'h0) begin
                        state_next = SSQ_DELAY;
                    end else if (state_reg == SSQ_RUN || delay_done) begin
                        state_next = SSQ_COAST; // R2 R7
                    end
                end else if (state_reg == SSQ_DELAY) begin
                    state_next = SSQ_RUN;
                end
            end
            SSQ_DECEL: begin
                if (run_cmd) begin
                    state_next = SSQ_RUN;
                end else if (motor_stopped_in) begin
                    state_next = SSQ_IDLE;
                end
            end
            SSQ_FDECEL: begin
                if (motor_stopped_in) begin
                    state_next = SSQ_FHOLD;
                end
            end
            SSQ_FHOLD: state_next = SSQ_FHOLD;
            default: state_next = SSQ_IDLE;
        endcase
        if (state_reg != SSQ_FHOLD && state_reg != SSQ_FDECEL && !mcu_seen_reg) begin
            if (mcu_fault_in || line_recog_reg) begin
                state_next = (fault_stop_mode_reg == SSQ_MODE_COAST) ? SSQ_FHOLD
                           : SSQ_FDECEL; // R13 R15
            end
        end
        if (state_reg == SSQ_FHOLD || state_reg == SSQ_FDECEL) begin
            if (fault_stop_mode_reg == SSQ_MODE_DECEL_RESTART && !mcu_seen_reg
                && !mcu_fault_in && !line_fault_in) begin
                state_next = SSQ_RUN; // R14 R20
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= SSQ_IDLE;
            drive_enable_out <= 1'b0;
            running_out <= 1'b0;
            decel_out <= 1'b0;
            start_from_zero_out <= 1'b0;
            reverse_out <= 1'b0;
            saved_rev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            drive_enable_out <= (state_next == SSQ_RUN) || (state_next == SSQ_DECEL)
                             || (state_next == SSQ_DELAY) || (state_next == SSQ_FDECEL);
            running_out <= (state_next == SSQ_RUN) || (state_next == SSQ_DECEL)
                        || (state_next == SSQ_DELAY) || (state_next == SSQ_FDECEL); // R5
            decel_out <= (state_next == SSQ_DECEL) || (state_next == SSQ_FDECEL); // R18
            start_from_zero_out <= (state_next == SSQ_RUN) && (state_reg == SSQ_COAST
                                || state_reg == SSQ_IDLE || state_reg == SSQ_FHOLD);
            if (line_onset) begin
                saved_rev_reg <= reverse_out; // R19
            end
            if (state_next == SSQ_RUN && (state_reg == SSQ_FDECEL || state_reg == SSQ_FHOLD)) begin
                reverse_out <= saved_rev_reg; // R19
            end else if (state_next == SSQ_RUN || state_next == SSQ_DELAY) begin
                reverse_out <= rev_cmd; // R3
            end
        end
    end

    // Fault code, alarm and history
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mcu_seen_reg <= 1'b0;
            alarm_reg <= 1'b0;
            pending_alarm_reg <= 1'b0;
            code_reg <= 8'h00;
            pending_code_reg <= 8'h00;
            history_reg <= 8'h00;
        end else begin
            if (mcu_fault_in && !mcu_seen_reg) begin
                mcu_seen_reg <= 1'b1; // R15
                pending_code_reg <= SSQ_MCU_CODE; // R16
                pending_alarm_reg <= 1'b1;
            end else if (line_recog_reg && state_reg != SSQ_FHOLD && state_reg != SSQ_FDECEL
                         && !mcu_seen_reg) begin
                pending_code_reg <= SSQ_LINE_CODE; // R16
                pending_alarm_reg <= (fault_stop_mode_reg != SSQ_MODE_DECEL_RESTART);
            end
            if (state_next == SSQ_FHOLD && state_reg != SSQ_FHOLD) begin
                code_reg <= mcu_fault_in && !mcu_seen_reg ? SSQ_MCU_CODE
                          : (line_recog_reg && state_reg != SSQ_FDECEL) ? SSQ_LINE_CODE
                          : pending_code_reg; // R13 R15
                alarm_reg <= alarm_reg || (mcu_fault_in && !mcu_seen_reg)
                          || (state_reg == SSQ_FDECEL ? pending_alarm_reg
                          : fault_stop_mode_reg != SSQ_MODE_DECEL_RESTART);
                if ((mcu_fault_in && !mcu_seen_reg) || (state_reg == SSQ_FDECEL
                    ? pending_alarm_reg : fault_stop_mode_reg != SSQ_MODE_DECEL_RESTART)) begin
                    history_reg <= (mcu_fault_in && !mcu_seen_reg) ? SSQ_MCU_CODE
                                 : (state_reg == SSQ_FDECEL ? pending_code_reg
                                 : SSQ_LINE_CODE); // R21
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fault_relay_output_out <= 1'b0;
            alarm_bit_out <= 1'b0;
            line_fault_code_out <= 8'h00;
            display_code_out <= 8'h00;
        end else begin
            fault_relay_output_out <= alarm_reg; // R17
            alarm_bit_out <= alarm_reg; // R17
            line_fault_code_out <= code_reg; // R16
            display_code_out <= (state_reg == SSQ_FHOLD) ? code_reg : history_reg; // R21
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_decel_stop;
        (state_reg == SSQ_RUN) && !run_cmd && !line_recog_reg && !mcu_fault_in
        && !mcu_seen_reg && (stop_method_setting_reg == SSQ_STOP_DECEL)
        |=> (state_reg == SSQ_DECEL) ##1 decel_out;
    endproperty
    a_decel_stop: assert property (p_decel_stop) else $error("no decel on stop"); // R1

    property p_delay_cut;
        (state_reg == SSQ_DELAY) && delay_done && !run_cmd && !line_recog_reg
        && !mcu_fault_in && !mcu_seen_reg && (stop_method_setting_reg != SSQ_STOP_DECEL)
        && (stop_method_setting_reg != SSQ_STOP_TWO_WIRE) |=> !drive_enable_out;
    endproperty
    a_delay_cut: assert property (p_delay_cut) else $error("output not cut"); // R2

    property p_two_wire_dir;
        two_wire && (state_next == SSQ_RUN) && (state_reg == SSQ_RUN)
        |=> (reverse_out == $past(reverse_run_input_in));
    endproperty
    a_two_wire_dir: assert property (p_two_wire_dir) else $error("bad direction"); // R3

    property p_run_ind;
        (state_reg == SSQ_IDLE) || (state_reg == SSQ_COAST) || (state_reg == SSQ_FHOLD)
        |-> !running_out && !drive_enable_out;
    endproperty
    a_run_ind: assert property (p_run_ind) else $error("run indicator mismatch"); // R5

    property p_zero_start;
        (state_reg == SSQ_COAST) && (state_next == SSQ_RUN) |=> start_from_zero_out;
    endproperty
    a_zero_start: assert property (p_zero_start) else $error("no zero start"); // R6

    property p_recog;
        $rose(line_recog_reg) |-> $past(line_fault_in, 1) && $past(line_fault_in, 2);
    endproperty
    a_recog: assert property (p_recog) else $error("early recognition"); // R8

    property p_no_recog;
        !line_fault_in |=> !line_recog_reg;
    endproperty
    a_no_recog: assert property (p_no_recog) else $error("fault after recovery"); // R9

    property p_count;
        line_onset && !restore_reg && !clear_write
        |=> line_fault_counter_reg == $past(line_fault_counter_reg) + 16'h1;
    endproperty
    a_count: assert property (p_count) else $error("count not advanced"); // R10

    property p_mode0;
        line_recog_reg && (fault_stop_mode_reg == SSQ_MODE_COAST) && !mcu_seen_reg
        && (state_reg != SSQ_FHOLD) |=> ##1 fault_relay_output_out && !drive_enable_out;
    endproperty
    a_mode0: assert property (p_mode0) else $error("mode 0 reaction wrong"); // R13

    property p_mcu_code;
        mcu_fault_in && !mcu_seen_reg && (fault_stop_mode_reg == SSQ_MODE_COAST)
        && (state_reg != SSQ_FHOLD) |=> ##1 (line_fault_code_out == SSQ_MCU_CODE);
    endproperty
    a_mcu_code: assert property (p_mcu_code) else $error("internal code wrong"); // R16

    c_delay_stop: cover property ((state_reg == SSQ_DELAY) ##1 (state_reg == SSQ_COAST));
    c_line_hold: cover property ((state_reg == SSQ_FHOLD) && (code_reg == SSQ_LINE_CODE));
    c_restart: cover property ((state_reg == SSQ_FDECEL) ##1 (state_reg == SSQ_RUN));
endmodule : ssq_sequencer

// ===== tb/ssq_partner.sv
// Ramp generator and non-volatile store seen from the sequencer
`timescale 1ns/1ps
module ssq_partner (
    // Clock and drive state
    input wire logic clk_in,
    input wire logic drive_enable_in,
    input wire logic decel_in,
    // Counter store
    input wire logic nv_save_in,
    input wire logic [15:0] nv_count_in,
    output logic [15:0] nv_store_out,
    // Ramp state
    output logic motor_stopped_out
);
    logic [3:0] ramp_reg = 4'h0;
    initial nv_store_out = 16'h0005;
    initial motor_stopped_out = 1'b1;
    always @(posedge clk_in) begin
        if (nv_save_in)
            nv_store_out <= nv_count_in;
        if (drive_enable_in && !decel_in) begin
            ramp_reg <= 4'h0;
            motor_stopped_out <= 1'b0;
        end else if (ramp_reg < 4'h5)
            ramp_reg <= ramp_reg + 4'h1;
        else
            motor_stopped_out <= 1'b1;
    end
endmodule : ssq_partner

// ===== tb/stop_and_link_fault_sequencer_tb_top.sv
// Testbench of the stop and link fault sequencer
`timescale 1ns/1ps
module stop_and_link_fault_sequencer_tb_top;
    import ssq_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h00000000, prd, r;
    logic rdy, err, e, fwd = 1'b0, rev = 1'b0, line = 1'b0, mcu = 1'b0, stp;
    logic [15:0] nvi, nvo;
    logic sv, den, dec, sfz, rvs, run, rel, alm, sfz_seen = 1'b0;
    logic [7:0] code, disp;
    int failures = 0, n_tests = 0;
    always #25 clk = ~clk;
    always @(posedge clk) if (sfz) sfz_seen <= 1'b1;
    ssq_sequencer #(.TENTH_CYCLES(20)) dut (.ref_clk_in(clk), .reset_n_in(rst_n),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .forward_run_input_in(fwd),
        .reverse_run_input_in(rev), .line_fault_in(line), .mcu_fault_in(mcu),
        .motor_stopped_in(stp), .nv_count_in(nvi), .nv_count_out(nvo), .nv_save_out(sv),
        .drive_enable_out(den), .decel_out(dec), .start_from_zero_out(sfz),
        .reverse_out(rvs), .running_out(run), .fault_relay_output_out(rel),
        .alarm_bit_out(alm), .line_fault_code_out(code), .display_code_out(disp));
    ssq_partner far_end (.clk_in(clk), .drive_enable_in(den), .decel_in(dec),
        .nv_save_in(sv), .nv_count_in(nvo), .nv_store_out(nvi), .motor_stopped_out(stp));
    task give_verdict;
        $display("Checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        n_tests++;
        if (g !== x) begin
            failures++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 20);
        if (k >= 20) begin
            failures++;
            give_verdict;
        end
        r = prd; e = err;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h00000000);
        chk("read", x, r);
    endtask : rd
    task wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task rst;
        @(posedge clk);
        rst_n <= 1'b0; fwd <= 1'b0; rev <= 1'b0; line <= 1'b0; mcu <= 1'b0;
        wt(8);
        rst_n <= 1'b1;
    endtask : rst
    initial begin
        rst;
        rd(SSQ_CTRL_OFS, 32'h0000270F);
        rd(SSQ_WAIT_OFS, 32'h00000000);
        rd(SSQ_COUNT_OFS, 32'h00000005);
        apb(1'b0, 8'h40, 32'h00000000);
        chk("pslverr", 32'h00000001, {31'h0, e});
        $display("Done registers");
        fwd <= 1'b1; wt(4);
        chk("running", 32'h00000001, {31'h0, run});
        fwd <= 1'b0; wt(3);
        chk("decel", 32'h00000001, {31'h0, dec});
        wt(12);
        chk("running", 32'h00000000, {31'h0, run});
        apb(1'b1, SSQ_CTRL_OFS, 32'h00000000);
        fwd <= 1'b1; wt(4);
        fwd <= 1'b0; wt(3);
        chk("drive", 32'h00000000, {31'h0, den});
        sfz_seen <= 1'b0; fwd <= 1'b1; wt(4);
        chk("zero start", 32'h00000001, {31'h0, sfz_seen});
        apb(1'b1, SSQ_CTRL_OFS, 32'h000022B8);
        rev <= 1'b1; wt(4);
        chk("reverse", 32'h00000001, {31'h0, rvs});
        chk("running", 32'h00000001, {31'h0, run});
        fwd <= 1'b0; rev <= 1'b0; wt(3);
        chk("decel", 32'h00000001, {31'h0, dec});
        wt(9);
        apb(1'b1, SSQ_CTRL_OFS, 32'h00000002);
        fwd <= 1'b1; wt(4);
        fwd <= 1'b0; wt(150);
        chk("drive", 32'h00000001, {31'h0, den});
        wt(300);
        chk("drive", 32'h00000000, {31'h0, den});
        apb(1'b1, SSQ_CTRL_OFS, 32'h000003EA);
        fwd <= 1'b1; wt(4);
        fwd <= 1'b0; wt(150);
        chk("drive", 32'h00000001, {31'h0, den});
        wt(300);
        chk("drive", 32'h00000000, {31'h0, den});
        $display("Done stop methods");
        apb(1'b1, SSQ_CTRL_OFS, 32'h0000270F);
        apb(1'b1, SSQ_WAIT_OFS, 32'h00000002);
        fwd <= 1'b1; wt(4);
        line <= 1'b1; wt(10);
        line <= 1'b0; wt(4);
        chk("code", 32'h00000000, {24'h0, code});
        chk("running", 32'h00000001, {31'h0, run});
        rd(SSQ_COUNT_OFS, 32'h00000006);
        apb(1'b1, SSQ_COUNT_OFS, 32'h00000000);
        rd(SSQ_COUNT_OFS, 32'h00000000);
        line <= 1'b1; wt(50);
        chk("code", {24'h0, SSQ_LINE_CODE}, {24'h0, code});
        chk("relay", 32'h00000001, {31'h0, rel});
        chk("alarm", 32'h00000001, {31'h0, alm});
        chk("drive", 32'h00000000, {31'h0, den});
        chk("display", {24'h0, SSQ_LINE_CODE}, {24'h0, disp});
        line <= 1'b0; wt(4);
        chk("relay", 32'h00000001, {31'h0, rel});
        rd(SSQ_HIST_OFS, {24'h0, SSQ_LINE_CODE});
        $display("Done line fault hold");
        rst;
        apb(1'b1, SSQ_CTRL_OFS, 32'h0002270F);
        fwd <= 1'b1; wt(4);
        line <= 1'b1; wt(20);
        chk("running", 32'h00000000, {31'h0, run});
        chk("relay", 32'h00000000, {31'h0, rel});
        chk("code", {24'h0, SSQ_LINE_CODE}, {24'h0, code});
        chk("display", {24'h0, SSQ_LINE_CODE}, {24'h0, disp});
        line <= 1'b0; wt(4);
        chk("running", 32'h00000001, {31'h0, run});
        chk("relay", 32'h00000000, {31'h0, rel});
        rd(SSQ_HIST_OFS, 32'h00000000);
        chk("display", 32'h00000000, {24'h0, disp});
        $display("Done line fault restart");
        rst;
        fwd <= 1'b1; wt(4);
        mcu <= 1'b1; wt(4);
        chk("code", {24'h0, SSQ_MCU_CODE}, {24'h0, code});
        chk("relay", 32'h00000001, {31'h0, rel});
        chk("drive", 32'h00000000, {31'h0, den});
        mcu <= 1'b0; wt(4);
        chk("relay", 32'h00000001, {31'h0, rel});
        $display("Done internal fault");
        give_verdict;
    end
endmodule : stop_and_link_fault_sequencer_tb_top
